// [rtl/panel_ctrl.v]
// Summary of operation
// - security 0 lets every parameter mode be entered and changed.
// - security 5 allows only level 0 mode, menu hidden.
// - security 6 allows only monitoring process value and set point.
// - key protect 1 blocks auto/manual, 2 run/reset, 3 both.
// - key protect resets to zero, both keys usable.
// - mode plus run/reset held one second leaves protect mode to level 0.
// - reset to run needs run/reset held one second.
// - run to reset needs run/reset held two seconds.
// - reset indicator lamp lit whenever in reset state.
// - reset requests ignored while auto tuning runs.
// - during reset output is the reset value, -5.0..105.0%, default 0.0%.
// - reset in manual mode keeps the manual value.
// - no limiters act on the reset value.
// - step count cut to or below current step while running ends the program.
// - two keys held one second toggle manual; exit goes to level 0.
// - program timing keeps advancing in manual mode.
// - manual mode suspends automatic display return.
// - manual up/down value applies after a two-second delay.
// - manual/auto switch while running ramps from the old output to the new value; in reset it jumps to the reset value.
// - after power loss in manual, manual resumes at the saved value.
// - 40% tuning start flashes the lamp; done clears lamp and parameter.
`timescale 1ns/100ps
`include "panel_ctrl_defines.vh"
module panel_ctrl #(
    parameter integer CLK_HZ = `CLK_HZ,
    parameter integer TICK_HZ = `TICK_HZ
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire key_mode,
    input wire key_run_reset,
    input wire key_auto_manual,
    input wire key_up,
    input wire key_down,
    input wire manual_restore,
    input wire [11:0] manual_restore_mv,
    output reg reset_indicator_lamp,
    output reg auto_tuning_lamp,
    output reg manual_mode,
    output reg program_run,
    output reg step_advance_en,
    output reg menu_visible,
    output reg display_autoreturn_en,
    output reg protect_mode,
    output reg [11:0] manipulated_variable
);

    // ****************************************************************
    // derived timing
    // ****************************************************************
    localparam integer TICK_DIV = CLK_HZ / TICK_HZ;
    // hold thresholds count ticks of the nominal rate; a faster TICK_HZ
    // only compresses time for simulation and keeps the counters small
    localparam integer T_RUN = (`HOLD_RUN_MS * `TICK_HZ + 999) / 1000;
    localparam integer T_RST = (`HOLD_RST_MS * `TICK_HZ + 999) / 1000;
    localparam integer T_PROT = (`HOLD_PROT_MS * `TICK_HZ + 999) / 1000;
    localparam integer T_MAN = (`HOLD_MAN_MS * `TICK_HZ + 999) / 1000;
    localparam integer T_MVD = (`MV_DELAY_MS * `TICK_HZ + 999) / 1000;
    localparam ST_RESET = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_AT = 2'h2;

    // ****************************************************************
    // tick divider
    // ****************************************************************
    reg [23:0] div_q;
    reg tick_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 24'h000000;
            tick_q <= 1'b0;
        end else if (div_q == TICK_DIV[23:0] - 24'h000001) begin
            div_q <= 24'h000000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 24'h000001;
            tick_q <= 1'b0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [2:0] security_q;
    reg [1:0] keyprot_q;
    reg signed [11:0] reset_mv_q;
    reg signed [11:0] auto_mv_q;
    reg [2:0] mode_req_q;
    reg [2:0] mode_q;
    reg [4:0] steps_q;
    reg [4:0] cur_step_q;
    reg keys_sw_q;
    reg at_req_q;
    reg at_done_q;
    reg [1:0] state_q;
    reg [7:0] addr_q;
    reg wr_q;
    reg rd_q;

    // access allowed per security level; reads keep working
    function mode_ok;
        input [2:0] sec;
        input [2:0] m;
        begin
            case (sec)
                3'h0: mode_ok = 1'b1;
                3'h1: mode_ok = (m != `MODE_CALIB);
                3'h2: mode_ok = (m <= `MODE_SETUP);
                3'h3: mode_ok = (m <= `MODE_LEVEL2);
                3'h4: mode_ok = (m <= `MODE_LEVEL1);
                3'h5: mode_ok = (m == `MODE_LEVEL0);
                default: mode_ok = 1'b0;
            endcase
        end
    endfunction

    wire setting_wr = wr_q && (security_q < 3'h6);
    wire [11:0] wv = hwdata[11:0];
    wire wv_ok = ($signed(wv) >= `MV_MIN) && ($signed(wv) <= `MV_MAX);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (hsel && hready && htrans[1]) begin
                addr_q <= haddr[7:0];
                wr_q <= hwrite;
                rd_q <= !hwrite;
                // one wait state per read, so a write finishing in the
                // same edge is already visible to the read
                if (!hwrite)
                    hreadyout <= 1'b0;
            end
            if (rd_q) begin
                case (addr_q)
                    `A_SECURITY: hrdata <= {29'h0, security_q};
                    `A_KEYPROT: hrdata <= {30'h0, keyprot_q};
                    `A_RESET_MV: hrdata <= {20'h0, reset_mv_q};
                    `A_AUTO_MV: hrdata <= {20'h0, auto_mv_q};
                    `A_CONTROL: hrdata <= {29'h0, at_done_q, at_req_q,
                                           keys_sw_q};
                    `A_STATUS: hrdata <= {24'h0, mode_q, state_q,
                                          manual_mode, protect_mode,
                                          reset_indicator_lamp};
                    `A_MODE_REQ: hrdata <= {29'h0, mode_req_q};
                    `A_STEPS: hrdata <= {27'h0, steps_q};
                    `A_CUR_STEP: hrdata <= {27'h0, cur_step_q};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************************************
    // key hold counters
    // ****************************************************************
    wire combo_prot = key_mode && key_run_reset;
    wire combo_man = key_mode && key_auto_manual;
    wire run_only = key_run_reset && !key_mode;
    reg [7:0] hold_run_q;
    reg [7:0] hold_prot_q;
    reg [7:0] hold_man_q;
    reg run_done_q;
    reg prot_done_q;
    reg man_done_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_run_q <= 8'h00;
            hold_prot_q <= 8'h00;
            hold_man_q <= 8'h00;
        end else begin
            if (!run_only)
                hold_run_q <= 8'h00;
            else if (tick_q && hold_run_q != 8'hff)
                hold_run_q <= hold_run_q + 8'h01;
            if (!combo_prot)
                hold_prot_q <= 8'h00;
            else if (tick_q && hold_prot_q != 8'hff)
                hold_prot_q <= hold_prot_q + 8'h01;
            if (!combo_man)
                hold_man_q <= 8'h00;
            else if (tick_q && hold_man_q != 8'hff)
                hold_man_q <= hold_man_q + 8'h01;
        end
    end

    // ****************************************************************
    // operating state, modes, manual value
    // ****************************************************************
    reg signed [11:0] man_mv_q;
    reg signed [11:0] man_pend_q;
    reg [7:0] mvd_q;
    reg pend_q;
    reg [7:0] flash_q;
    reg run_key_ok;
    reg am_key_ok;
    always @* begin
        run_key_ok = !keyprot_q[1];
        am_key_ok = !keyprot_q[0];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            security_q <= `SEC_RESET;
            keyprot_q <= `KP_RESET;
            reset_mv_q <= `RESET_MV_DEF;
            auto_mv_q <= 12'sh000;
            mode_q <= `MODE_LEVEL0;
            mode_req_q <= `MODE_LEVEL0;
            steps_q <= `STEPS_DEF;
            cur_step_q <= 5'h00;
            keys_sw_q <= 1'b0;
            at_req_q <= 1'b0;
            at_done_q <= 1'b0;
            state_q <= ST_RESET;
            run_done_q <= 1'b0;
            prot_done_q <= 1'b0;
            man_done_q <= 1'b0;
            man_mv_q <= 12'sh000;
            man_pend_q <= 12'sh000;
            mvd_q <= 8'h00;
            pend_q <= 1'b0;
            flash_q <= 8'h00;
            manual_mode <= 1'b0;
            protect_mode <= 1'b0;
        end else begin
            if (tick_q)
                flash_q <= flash_q + 8'h01;
            if (manual_restore) begin
                manual_mode <= 1'b1;
                man_mv_q <= manual_restore_mv;
            end
            if (setting_wr) begin
                case (addr_q)
                    `A_SECURITY: if (hwdata[2:0] <= 3'h6)
                        security_q <= hwdata[2:0];
                    `A_KEYPROT: keyprot_q <= hwdata[1:0];
                    `A_RESET_MV: if (wv_ok) reset_mv_q <= wv;
                    `A_AUTO_MV: auto_mv_q <= wv;
                    `A_MODE_REQ: begin
                        mode_req_q <= hwdata[2:0];
                        if (mode_ok(security_q, hwdata[2:0]) &&
                            !manual_mode)
                            mode_q <= hwdata[2:0];
                    end
                    `A_STEPS: begin
                        steps_q <= hwdata[4:0];
                        if (state_q != ST_RESET &&
                            hwdata[4:0] <= cur_step_q)
                            state_q <= ST_RESET;
                    end
                    `A_CUR_STEP: cur_step_q <= hwdata[4:0];
                    `A_CONTROL: begin
                        keys_sw_q <= hwdata[`CTL_KEYS_SW];
                        if (hwdata[`CTL_AT_START] && state_q == ST_RUN) begin
                            at_req_q <= 1'b1;
                            state_q <= ST_AT;
                        end
                    end
                    default: ;
                endcase
            end
            if (at_done_q && state_q == ST_AT) begin
                at_req_q <= 1'b0;
                state_q <= ST_RUN;
            end
            at_done_q <= setting_wr && addr_q == `A_CONTROL &&
                         hwdata[`CTL_AT_DONE];
            // one action per hold, re-armed on release
            if (!run_only)
                run_done_q <= 1'b0;
            else if (!run_done_q && run_key_ok) begin
                if (state_q == ST_RESET && hold_run_q >= T_RUN[7:0]) begin
                    state_q <= ST_RUN;
                    run_done_q <= 1'b1;
                end else if (state_q == ST_RUN &&
                             hold_run_q >= T_RST[7:0]) begin
                    state_q <= ST_RESET;
                    run_done_q <= 1'b1;
                end
            end
            // in ST_AT neither branch matches, so tuning cannot be reset by the run/reset key
            if (!combo_prot)
                prot_done_q <= 1'b0;
            else if (!prot_done_q && hold_prot_q >= T_PROT[7:0]) begin
                prot_done_q <= 1'b1;
                protect_mode <= !protect_mode;
                mode_q <= `MODE_LEVEL0;
            end
            if (!combo_man)
                man_done_q <= 1'b0;
            else if (!man_done_q && am_key_ok &&
                     hold_man_q >= T_MAN[7:0]) begin
                man_done_q <= 1'b1;
                manual_mode <= !manual_mode;
                mode_q <= `MODE_LEVEL0;
                if (!manual_mode)
                    man_mv_q <= manipulated_variable;
            end
            if (manual_mode && (key_up || key_down) && tick_q) begin
                if (key_up && man_pend_q < `MV_MAX)
                    man_pend_q <= man_pend_q + 12'sh001;
                else if (key_down && man_pend_q > `MV_MIN)
                    man_pend_q <= man_pend_q - 12'sh001;
                pend_q <= 1'b1;
                mvd_q <= 8'h00;
            end else if (pend_q && tick_q) begin
                if (mvd_q >= T_MVD[7:0] - 8'h01) begin
                    man_mv_q <= man_pend_q;
                    pend_q <= 1'b0;
                end else
                    mvd_q <= mvd_q + 8'h01;
            end else if (!pend_q)
                man_pend_q <= man_mv_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    wire signed [11:0] target = manual_mode ? man_mv_q :
        (state_q == ST_RESET) ? reset_mv_q : auto_mv_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            manipulated_variable <= 12'sh000;
            reset_indicator_lamp <= 1'b1;
            auto_tuning_lamp <= 1'b0;
            program_run <= 1'b0;
            step_advance_en <= 1'b0;
            menu_visible <= 1'b1;
            display_autoreturn_en <= 1'b1;
        end else begin
            if (manipulated_variable == target)
                manipulated_variable <= target;
            else if (tick_q && $signed(manipulated_variable) < target)
                manipulated_variable <= manipulated_variable + 12'h001;
            else if (tick_q)
                manipulated_variable <= manipulated_variable - 12'h001;
            // the reset value bypasses the ramp and every limiter
            if (state_q == ST_RESET && !manual_mode)
                manipulated_variable <= reset_mv_q;
            // a power-on restore resumes at the saved value, not ramped
            if (manual_restore)
                manipulated_variable <= manual_restore_mv;
            reset_indicator_lamp <= (state_q == ST_RESET);
            auto_tuning_lamp <= at_req_q && flash_q[4];
            program_run <= (state_q != ST_RESET);
            step_advance_en <= (state_q != ST_RESET);
            menu_visible <= (security_q < 3'h5) && !manual_mode;
            display_autoreturn_en <= !manual_mode;
        end
    end
endmodule

// [rtl/panel_ctrl_defines.vh]
`ifndef PANEL_CTRL_DEFINES_VH
`define PANEL_CTRL_DEFINES_VH

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define A_SECURITY 8'h00
`define A_KEYPROT 8'h04
`define A_RESET_MV 8'h08
`define A_AUTO_MV 8'h0c
`define A_CONTROL 8'h10
`define A_STATUS 8'h14
`define A_MODE_REQ 8'h18
`define A_STEPS 8'h1c
`define A_CUR_STEP 8'h20

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTL_KEYS_SW 0
`define CTL_AT_START 1
`define CTL_AT_DONE 2
`define SEC_RESET 3'h1
`define KP_RESET 2'h0
`define RESET_MV_DEF 12'sh000
`define MV_MIN 12'shfce
`define MV_MAX 12'sh41a
`define STEPS_DEF 5'h08

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 125000000
`define TICK_HZ 100
`define HOLD_RUN_MS 1000
`define HOLD_RST_MS 2000
`define HOLD_PROT_MS 1000
`define HOLD_MAN_MS 1000
`define MV_DELAY_MS 2000

// ****************************************************************
// display modes
// ****************************************************************
`define MODE_LEVEL0 3'h0
`define MODE_PROGRAM 3'h1
`define MODE_LEVEL1 3'h2
`define MODE_LEVEL2 3'h3
`define MODE_SETUP 3'h4
`define MODE_EXPANSION 3'h5
`define MODE_OPTION 3'h6
`define MODE_CALIB 3'h7
`endif

// [tb/key_operator.sv]
`timescale 1ns/100ps
module key_operator (
    input wire logic hclk,
    output logic key_mode,
    output logic key_run_reset,
    output logic key_auto_manual,
    output logic key_up,
    output logic key_down
);
    // keys {mode,run,auto_manual,up,down}; released keys read as not pressed
    logic [4:0] keys_q = 5'h00;
    assign {key_mode, key_run_reset, key_auto_manual, key_up,
            key_down} = keys_q;
    task automatic hold(input logic [4:0] k, input int cyc);
        keys_q <= k;
        repeat (cyc) @(posedge hclk);
        keys_q <= 5'h00;
        @(posedge hclk);
    endtask
endmodule

// [tb/panel_ctrl_props.sv]
`timescale 1ns/100ps
module panel_ctrl_props #(
    parameter integer CLK_HZ = 125000000,
    parameter integer TICK_HZ = 100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic key_mode,
    input wire logic key_run_reset,
    input wire logic key_auto_manual,
    input wire logic manual_restore,
    input wire logic reset_indicator_lamp,
    input wire logic manual_mode,
    input wire logic program_run,
    input wire logic step_advance_en,
    input wire logic display_autoreturn_en,
    input wire logic protect_mode
);
    localparam int DIV = CLK_HZ / TICK_HZ;
    // one tick of slack for the free-running tick phase
    localparam int RUN_MIN = 99 * DIV;
    localparam int STOP_MIN = 199 * DIV;
    logic [31:0] run_cnt_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            run_cnt_q <= 32'h0;
        else if (key_run_reset && !key_mode)
            run_cnt_q <= run_cnt_q + 32'h1;
        else
            run_cnt_q <= 32'h0;
    end
    bus_okay_a: assert property (hresp == 1'b0)
        else $error("bus answer not okay");
    bus_wait_a: assert property (!hreadyout |=> hreadyout)
        else $error("read wait state longer than one cycle");
    lamp_state_a: assert property (
        reset_indicator_lamp |-> !program_run)
        else $error("reset lamp lit while running");
    run_hold_a: assert property (
        $rose(program_run) |-> $past(run_cnt_q) >= RUN_MIN)
        else $error("run started on a short hold");
    stop_hold_a: assert property (
        $fell(program_run) && $past(key_run_reset)
        |-> $past(run_cnt_q) >= STOP_MIN)
        else $error("run stopped on a short hold");
    protect_keys_a: assert property (
        $changed(protect_mode) |-> $past(key_mode && key_run_reset))
        else $error("protect mode changed without its key pair");
    manual_keys_a: assert property (
        $changed(manual_mode) |-> $past(key_mode && key_auto_manual)
        || $past(manual_restore) || $past(manual_restore, 2))
        else $error("manual mode changed without cause");
    manual_noreturn_a: assert property (
        manual_mode [*3] |-> !display_autoreturn_en)
        else $error("display return active in manual mode");
    step_keep_a: assert property (
        program_run [*2] |-> step_advance_en)
        else $error("step timing halted while running");
endmodule
bind panel_ctrl panel_ctrl_props #(.CLK_HZ(CLK_HZ), .TICK_HZ(TICK_HZ))
    i_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .key_mode(key_mode), .key_run_reset(key_run_reset),
    .key_auto_manual(key_auto_manual), .manual_restore(manual_restore),
    .reset_indicator_lamp(reset_indicator_lamp),
    .manual_mode(manual_mode), .program_run(program_run),
    .step_advance_en(step_advance_en),
    .display_autoreturn_en(display_autoreturn_en),
    .protect_mode(protect_mode));

// [tb/tb.sv]
`timescale 1ns/100ps
`include "panel_ctrl_defines.vh"
module tb;
    localparam int T = 4;
    localparam logic [4:0] RUN = 5'h08, MA = 5'h14, MR = 5'h18, UP = 5'h02;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, manual_restore = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [11:0] manual_restore_mv = 0, mv, mv0;
    logic hreadyout, hresp, lamp, at_lamp, man, run, step_en, menu, aret, prot;
    wire logic k_mode, k_run, k_am, k_up, k_dn;
    int fails = 0, num_checks = 0;
    always #4 hclk = ~hclk;
    key_operator i_op (.hclk(hclk), .key_mode(k_mode), .key_run_reset(k_run),
        .key_auto_manual(k_am), .key_up(k_up), .key_down(k_dn));
    panel_ctrl #(.CLK_HZ(125000000), .TICK_HZ(31250000)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .key_mode(k_mode), .key_run_reset(k_run),
        .key_auto_manual(k_am), .key_up(k_up), .key_down(k_dn),
        .manual_restore(manual_restore),
        .manual_restore_mv(manual_restore_mv),
        .reset_indicator_lamp(lamp), .auto_tuning_lamp(at_lamp),
        .manual_mode(man), .program_run(run), .step_advance_en(step_en),
        .menu_visible(menu), .display_autoreturn_en(aret),
        .protect_mode(prot), .manipulated_variable(mv));
    // ****************************************************************
    // bench tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 100) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(string name, input logic [7:0] a, input int exp);
        bus(1'b0, a, 0);
        check(name, exp, rd);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("security", `A_SECURITY, 1);
        rchk("keyprot", `A_KEYPROT, 0);
        rchk("reset_mv", `A_RESET_MV, 0);
        check("lamp", 1, lamp);
        i_op.hold(RUN, 90 * T);
        check("run short", 0, run);
        i_op.hold(RUN, 110 * T);
        check("run", 1, run);
        check("lamp run", 0, lamp);
        i_op.hold(RUN, 190 * T);
        check("stop short", 1, run);
        i_op.hold(RUN, 210 * T);
        check("stop", 0, run);
        check("lamp stop", 1, lamp);
        wr(`A_RESET_MV, 32'h41a);
        repeat (4) @(posedge hclk);
        check("mv at reset", 12'h41a, mv);
        wr(`A_RESET_MV, 32'h41b);
        rchk("reset_mv range", `A_RESET_MV, 32'h41a);
        wr(`A_RESET_MV, 32'hfce);
        repeat (4) @(posedge hclk);
        check("mv low", 12'hfce, mv);
        for (int kp = 1; kp < 4; kp++) begin
            wr(`A_KEYPROT, kp);
            i_op.hold(RUN, 110 * T);
            check("kp run", kp == 1, run);
            if (run === 1'b1)
                i_op.hold(RUN, 210 * T);
            i_op.hold(MA, 110 * T);
            check("kp manual", kp == 2, man);
            if (man === 1'b1)
                i_op.hold(MA, 110 * T);
        end
        wr(`A_KEYPROT, 0);
        i_op.hold(MA, 110 * T);
        check("manual", 1, man);
        check("autoreturn", 0, aret);
        i_op.hold(UP, 10 * T);
        mv0 = mv;
        repeat (150 * T) @(posedge hclk);
        check("mv delayed", mv0, mv);
        repeat (80 * T) @(posedge hclk);
        num_checks++;
        if (mv === mv0 || mv === 12'hfce) begin
            fails++;
            $display("CHECK FAILED mv update expected not %h seen %h",
                     mv0, mv);
        end
        i_op.hold(RUN, 110 * T);
        check("run manual", 1, run);
        check("step_en", 1, step_en);
        i_op.hold(MA, 110 * T);
        check("manual off", 0, man);
        bus(1'b0, `A_STATUS, 0);
        check("mode level0", 0, rd[7:5]);
        wr(`A_CONTROL, 32'h2);
        rchk("at start", `A_CONTROL, 32'h2);
        for (int n = 0; n < 40 * T && at_lamp !== 1'b1; n++)
            @(posedge hclk);
        check("at lamp flash", 1, at_lamp);
        i_op.hold(RUN, 210 * T);
        check("no stop in tuning", 1, run);
        wr(`A_CONTROL, 32'h4);
        bus(1'b0, `A_CONTROL, 0);
        check("at cancel", 0, rd[1]);
        check("at lamp", 0, at_lamp);
        wr(`A_STEPS, 0);
        repeat (4) @(posedge hclk);
        check("step cut", 0, run);
        i_op.hold(MR, 110 * T);
        check("protect", 1, prot);
        i_op.hold(MR, 110 * T);
        check("protect off", 0, prot);
        wr(`A_SECURITY, 0);
        repeat (2) @(posedge hclk);
        check("menu sec0", 1, menu);
        wr(`A_MODE_REQ, `MODE_CALIB);
        bus(1'b0, `A_STATUS, 0);
        check("calib open", `MODE_CALIB, rd[7:5]);
        wr(`A_SECURITY, 5);
        repeat (2) @(posedge hclk);
        check("menu sec5", 0, menu);
        wr(`A_MODE_REQ, `MODE_LEVEL0);
        wr(`A_MODE_REQ, `MODE_LEVEL1);
        bus(1'b0, `A_STATUS, 0);
        check("level1 shut", `MODE_LEVEL0, rd[7:5]);
        manual_restore_mv <= 12'h123;
        manual_restore <= 1'b1;
        @(posedge hclk);
        manual_restore <= 1'b0;
        repeat (4) @(posedge hclk);
        check("restore manual", 1, man);
        check("restore mv", 12'h123, mv);
        wr(`A_SECURITY, 6);
        wr(`A_KEYPROT, 3);
        rchk("monitor only", `A_KEYPROT, 0);
        give_verdict();
    end
endmodule
